// >>> hw/sar_params.svh
// Constants for the serial readout of the 14-bit converter.
// Assumes inclusion by bare name from the design files.
`ifndef SAR_PARAMS_SVH
`define SAR_PARAMS_SVH

// ==========================================
// Frame layout, in falling serial clock edges
`define SAR_HOLD_EDGE 5'h06
`define SAR_MSB_EDGE 5'h08
`define SAR_LAST_SUB_EDGE 5'h17
`define SAR_LSB_EDGE 5'h15
`define SAR_FRAME_EDGES 5'h18
`define SAR_EDGE_MAX 5'h1F

// ==========================================
// Result word
`define SAR_RESULT_BITS 14
`define SAR_SUB_BITS 2
`define SAR_WORD_BITS 16
`define SAR_WORD_RESET 16'h0000
`define SAR_FIFO_DEPTH 4

`endif

// >>> hw/sar_pkg.sv
// Types shared by the serial readout design.
// Assumes nothing of its surroundings.
package sar_pkg;

    // ==========================================
    // Frame sequencer states
    typedef enum logic [3:0] {
        SAR_SHUTDOWN = 4'h1,
        SAR_ACQUIRE = 4'h2,
        SAR_CONVERT = 4'h4,
        SAR_TRAIL = 4'h8
    } sar_state_t;

endpackage

// >>> hw/sar_readout.sv
// Serial readout of the 14-bit converter, with its result buffer.
// Assumes chip select and serial clock arrive asynchronously on pins,
// and that the converter core pushes result words with valid/ready.
`timescale 1ns/1ps
`include "sar_params.svh"

// ==========================================
// Result buffer
module sar_fifo #(
    parameter int WIDTH = `SAR_WORD_BITS,
    parameter int DEPTH = `SAR_FIFO_DEPTH
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [WIDTH-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    output logic [WIDTH-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic empty;
    logic [DEPTH-1:0] wr_sel;

    // Ready is a register so the top's ready output leaves a flip-flop
    wire do_push = in_valid_in & in_ready_out;
    wire do_pop = out_ready_in & ~empty;
    wire [CW-1:0] next_count = count + CW'(do_push) - CW'(do_pop);
    wire [PW-1:0] wr_next = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
    wire [PW-1:0] rd_next = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);

    assign out_valid_out = ~empty;
    assign out_data_out = mem[rd_ptr];

    // ==========================================
    // Storage, one write strobe per entry
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi = gi + 1)
        begin : g_wr_sel
            assign wr_sel[gi] = do_push & (wr_ptr == PW'(gi));
        end
    endgenerate

    always_ff @(posedge clk_in)
    begin
        for (int i = 0; i < DEPTH; i++)
        begin
            if (wr_sel[i])
            begin
                mem[i] <= in_data_in;
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready_out <= 1'b0;
            empty <= 1'b1;
        end
        else
        begin
            wr_ptr <= do_push ? wr_next : wr_ptr;
            rd_ptr <= do_pop ? rd_next : rd_ptr;
            count <= next_count;
            in_ready_out <= (next_count != CW'(DEPTH));
            empty <= (next_count == '0);
        end
    end
endmodule // sar_fifo

// ==========================================
// Frame sequencer and shifter
module sar_readout #(
    parameter int FIFO_DEPTH = `SAR_FIFO_DEPTH
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic cs_n_in,
    input wire logic sclk_in,
    input wire logic [`SAR_WORD_BITS-1:0] result_data_in,
    input wire logic result_valid_in,
    output logic result_ready_out,
    output logic dout_out,
    output logic dout_oe_out,
    output logic powered_out,
    output logic sample_hold_out,
    output logic conv_busy_out,
    output logic abort_out
);
    // ==========================================
    // Pin synchronisers
    // Two stages before any logic reads the pins
    logic cs_meta;
    logic cs_sync;
    logic sclk_meta;
    logic sclk_sync;
    logic sclk_prev;

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            sclk_meta <= 1'b0;
            sclk_sync <= 1'b0;
            sclk_prev <= 1'b0;
        end
        else
        begin
            cs_meta <= cs_n_in;
            cs_sync <= cs_meta;
            sclk_meta <= sclk_in;
            sclk_sync <= sclk_meta;
            sclk_prev <= sclk_sync;
        end
    end

    wire sclk_fall = sclk_prev & ~sclk_sync;

    // ==========================================
    // Decode
    sar_pkg::sar_state_t state;
    sar_pkg::sar_state_t next_state;
    logic [4:0] edge_cnt;
    logic [`SAR_WORD_BITS-1:0] shreg;

    wire [4:0] next_cnt = (edge_cnt == `SAR_EDGE_MAX) ? edge_cnt : edge_cnt + 5'h01;
    wire in_shutdown = (state == sar_pkg::SAR_SHUTDOWN);
    wire hold_edge = sclk_fall & (state == sar_pkg::SAR_ACQUIRE) & (next_cnt == `SAR_HOLD_EDGE);
    wire abort_now = cs_sync & ((state == sar_pkg::SAR_ACQUIRE) | (state == sar_pkg::SAR_CONVERT));
    wire data_edge = (next_cnt >= `SAR_MSB_EDGE) & (next_cnt <= `SAR_LAST_SUB_EDGE);
    wire fifo_valid;
    wire fifo_ready;
    wire [`SAR_WORD_BITS-1:0] fifo_data;
    // empty buffer reads as code zero
    wire [`SAR_WORD_BITS-1:0] load_word = fifo_valid ? fifo_data : `SAR_WORD_RESET;
    // Frame clear, from reset or deselect
    wire frame_clear = srst_in | cs_sync;
    // one bit order for bursts and byte reads
    wire [`SAR_WORD_BITS-1:0] next_shreg = {shreg[`SAR_WORD_BITS-2:0], 1'b0};
    wire next_dout = data_edge ? shreg[`SAR_WORD_BITS-1] : 1'b0;
    wire next_hold = (next_state == sar_pkg::SAR_CONVERT)
                   | (next_state == sar_pkg::SAR_TRAIL);
    wire next_busy = (next_state == sar_pkg::SAR_CONVERT);
    wire next_abort = abort_now & (state == sar_pkg::SAR_CONVERT);

    sar_fifo #(
        .WIDTH(`SAR_WORD_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .in_data_in(result_data_in),
        .in_valid_in(result_valid_in),
        .in_ready_out(fifo_ready),
        .out_data_out(fifo_data),
        .out_valid_out(fifo_valid),
        .out_ready_in(hold_edge)
    );

    assign result_ready_out = fifo_ready;

    always_comb
    begin
        next_state = state;
        case (state)
            sar_pkg::SAR_SHUTDOWN:
            begin
                if (!cs_sync)
                begin
                    next_state = sar_pkg::SAR_ACQUIRE;
                end
            end
            sar_pkg::SAR_ACQUIRE:
            begin
                if (cs_sync)
                begin
                    next_state = sar_pkg::SAR_SHUTDOWN;
                end
                else if (hold_edge)
                begin
                    next_state = sar_pkg::SAR_CONVERT;
                end
            end
            sar_pkg::SAR_CONVERT:
            begin
                if (cs_sync)
                begin
                    next_state = sar_pkg::SAR_SHUTDOWN;
                end
                else if (sclk_fall && next_cnt == `SAR_LSB_EDGE)
                begin
                    next_state = sar_pkg::SAR_TRAIL;
                end
            end
            sar_pkg::SAR_TRAIL:
            begin
                if (cs_sync)
                begin
                    next_state = sar_pkg::SAR_SHUTDOWN;
                end
            end
            default:
            begin
                next_state = sar_pkg::SAR_SHUTDOWN;
            end
        endcase
    end

    // ==========================================
    // State, counter and shifter
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            state <= sar_pkg::SAR_SHUTDOWN;
        end
        else
        begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (frame_clear)
        begin
            edge_cnt <= 5'h00;
        end
        else if (sclk_fall)
        begin
            edge_cnt <= next_cnt;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (frame_clear)
        begin
            shreg <= `SAR_WORD_RESET;
        end
        else if (hold_edge)
        begin
            shreg <= load_word;
        end
        else if (sclk_fall && data_edge)
        begin
            shreg <= next_shreg;
        end
    end

    // ==========================================
    // Data pin and its output enable
    always_ff @(posedge clk_in)
    begin
        if (frame_clear)
        begin
            dout_out <= 1'b0;
            dout_oe_out <= 1'b0;
        end
        else if (in_shutdown)
        begin
            dout_out <= 1'b0;
            dout_oe_out <= 1'b1;
        end
        // output moves on falling edges only
        else if (sclk_fall)
        begin
            dout_out <= next_dout;
            dout_oe_out <= 1'b1;
        end
    end

    // ==========================================
    // Status outputs
    // Status follows the next state, in step with the state register
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            powered_out <= 1'b0;
            sample_hold_out <= 1'b0;
            conv_busy_out <= 1'b0;
            abort_out <= 1'b0;
        end
        else
        begin
            powered_out <= ~cs_sync;
            sample_hold_out <= next_hold;
            conv_busy_out <= next_busy;
            abort_out <= next_abort;
        end
    end
endmodule // sar_readout

// >>> dv/sar_readout_monitor.sv
// Checker for the serial readout pins.
// Bound to sar_readout; sees only its ports.
`timescale 1ns/1ps
module sar_readout_monitor #(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic cs_n_in,
    input wire logic sclk_in,
    input wire logic [15:0] result_data_in,
    input wire logic result_valid_in,
    input wire logic result_ready_out,
    input wire logic dout_out,
    input wire logic dout_oe_out,
    input wire logic powered_out,
    input wire logic sample_hold_out,
    input wire logic conv_busy_out,
    input wire logic abort_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);
    // ==========================================
    // Pin relations
    sequence s_quiet;
        cs_n_in [*6];
    endsequence
    sequence s_active;
        !cs_n_in [*6];
    endsequence
    chk_idle_undriven: assert property (s_quiet |-> !dout_oe_out && !powered_out)
        else $error("output driven while deselected");
    chk_select_powered: assert property (s_active |-> powered_out)
        else $error("not powered while selected");
    chk_start_low: assert property ($rose(dout_oe_out) |-> !dout_out && powered_out)
        else $error("output not low at start");
    chk_fall_only: assert property ($changed(dout_out) && dout_oe_out && $past(dout_oe_out)
        |-> !$past(sclk_in, 3))
        else $error("output changed away from falling clock");
    chk_hold_busy: assert property ($rose(sample_hold_out) |-> $rose(conv_busy_out))
        else $error("hold and conversion start apart");
    chk_abort_off: assert property (abort_out |=> !abort_out ##[0:2] !powered_out)
        else $error("abort did not shut down");
    chk_clear_all: assert property ($fell(powered_out) |-> ##[0:1] (!dout_oe_out
        && !sample_hold_out && !conv_busy_out && !dout_out))
        else $error("state left after shutdown");
    chk_oe_power: assert property (dout_oe_out |-> powered_out)
        else $error("driven while powered down");
    // ==========================================
    // Falling serial clock edges seen on the pin this frame
    logic sclk_seen;
    logic [4:0] falls;
    always_ff @(posedge clk_in)
    begin
        if (srst_in || cs_n_in)
        begin
            sclk_seen <= 1'b0;
            falls <= 5'h00;
        end
        else
        begin
            sclk_seen <= sclk_in;
            if (sclk_seen && !sclk_in && falls != 5'h1F)
            begin
                falls <= falls + 5'h01;
            end
        end
    end
    sequence s_hold_start;
        $rose(sample_hold_out);
    endsequence
    sequence s_busy_end;
        $fell(conv_busy_out) && powered_out;
    endsequence
    chk_hold_sixth: assert property (s_hold_start |-> falls == 5'h06)
        else $error("hold not at sixth falling edge");
    chk_busy_end: assert property (s_busy_end |-> falls == 5'h15)
        else $error("conversion did not end with last result bit");
endmodule // sar_readout_monitor

bind sar_readout sar_readout_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) sar_readout_monitor_i (
    .clk_in(clk_in), .srst_in(srst_in), .cs_n_in(cs_n_in), .sclk_in(sclk_in),
    .result_data_in(result_data_in), .result_valid_in(result_valid_in),
    .result_ready_out(result_ready_out), .dout_out(dout_out), .dout_oe_out(dout_oe_out),
    .powered_out(powered_out), .sample_hold_out(sample_hold_out),
    .conv_busy_out(conv_busy_out), .abort_out(abort_out));

// >>> dv/sar_host_model.sv
// Host serial controller, clock master of the link.
// Assumes tb_top calls frame and reads rx afterwards.
`timescale 1ns/1ps
module sar_host_model (
    input wire logic dout_in,
    input wire logic dout_oe_in,
    output logic cs_n_out,
    output logic sclk_out
);
    logic [31:0] rx = 32'h00000000;
    initial
    begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
    end
    // ==========================================
    // One frame of n clocks, burst or bytes
    task automatic frame(input int n, input bit bytes);
        rx = 32'h00000000;
        #1.3;
        cs_n_out = 1'b0;
        #24;
        for (int i = 0; i < n; i++)
        begin
            // sample on rise, 48 ns period
            sclk_out = 1'b1;
            rx = {rx[30:0], dout_oe_in ? dout_in : 1'b1};
            #24;
            sclk_out = 1'b0;
            #24;
            if (bytes && i % 8 == 7)
                #200;
        end
        // release after last fall, long gap
        cs_n_out = 1'b1;
        #80;
    endtask
endmodule // sar_host_model

// >>> dv/tb_top.sv
// Self-checking bench for the serial readout.
// Assumes the host model drives the link pins asynchronously.
`timescale 1ns/1ps
module tb_top;
    localparam int DEPTH = 4;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [15:0] result_data_in = 16'h0000;
    logic result_valid_in = 1'b0;
    logic result_ready_out, dout_out, dout_oe_out, powered_out;
    logic sample_hold_out, conv_busy_out, abort_out, cs_n, sclk;
    logic [31:0] seed = 32'hC3E33A89;
    logic [15:0] words[$];
    int miscompares = 0;
    int checked = 0;
    int aborts = 0;
    always #2 clk_in = ~clk_in;
    always @(posedge clk_in)
        if (abort_out === 1'b1)
            aborts++;
    sar_readout #(.FIFO_DEPTH(DEPTH)) sar_readout_i (.clk_in(clk_in), .srst_in(srst_in),
        .cs_n_in(cs_n), .sclk_in(sclk), .result_data_in(result_data_in),
        .result_valid_in(result_valid_in), .result_ready_out(result_ready_out),
        .dout_out(dout_out), .dout_oe_out(dout_oe_out), .powered_out(powered_out),
        .sample_hold_out(sample_hold_out), .conv_busy_out(conv_busy_out),
        .abort_out(abort_out));
    sar_host_model sar_host_model_i (.dout_in(dout_out), .dout_oe_in(dout_oe_out),
        .cs_n_out(cs_n), .sclk_out(sclk));
    // ==========================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic check_count(input string what, input int exp, input int seen);
        check_word(what, exp, seen);
    endtask
    task automatic fill();
        @(posedge clk_in);
        result_valid_in <= 1'b1;
        result_data_in <= seed[15:0];
        for (int k = 0; k < 12; k++)
        begin
            @(posedge clk_in);
            if (result_ready_out === 1'b1)
            begin
                words.push_back(result_data_in);
                seed = lfsr(seed);
                result_data_in <= seed[15:0];
            end
        end
        result_valid_in <= 1'b0;
    endtask
    task automatic run_frame(input int n, input bit bytes);
        logic [15:0] w;
        w = (words.size() > 0) ? words.pop_front() : 16'h0000;
        sar_host_model_i.frame(n, bytes);
        check_word("frame", {16'h0000, w} << (n - 24), sar_host_model_i.rx);
    endtask
    task automatic close_out();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial
    begin
        #200000;
        miscompares++;
        close_out();
    end
    initial
    begin
        repeat (12) @(posedge clk_in);
        srst_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        fill();
        check_count("buffered words", DEPTH, words.size());
        for (int f = 0; f < 5; f++)
            run_frame(24 + 4 * (f % 2), f[1]);
        check_word("idle enable", 32'h00000000, {31'h0, dout_oe_out});
        fill();
        sar_host_model_i.frame(12, 1'b0);
        check_word("abort power", 32'h00000000, {31'h0, powered_out});
        void'(words.pop_front());
        check_count("aborts", 1, aborts);
        run_frame(24, 1'b1);
        close_out();
    end
endmodule // tb_top
